//--- eccr_pkg.sv
package eccr_pkg;

    // Register map, byte addresses on a 12-bit APB window
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_STATUS = 12'h020;
    localparam logic [11:0] ADDR_CLOCK = 12'h024;
    localparam logic [11:0] ADDR_CARD = 12'h028;
    localparam logic [11:0] ADDR_LOAD = 12'h02C;
    localparam logic [11:0] ADDR_DIO = 12'h030;
    localparam logic [11:0] ADDR_PRESET = 12'h034;

    localparam int NCH = 4;

    // Status / enable layout (same positions in both)
    localparam int POS_UP = 0;
    localparam int POS_DOWN = 4;
    localparam int POS_MARK = 8;
    localparam int POS_DIN = 12;
    localparam int POS_ABOVE = 16;
    localparam int POS_BELOW = 20;
    localparam int POS_TICK = 28;
    localparam int POS_ALL = 31;

    // Clock setup fields
    localparam int SRATE_LSB = 0;
    localparam int DIV_LSB = 16;
    localparam int TBASE_LSB = 24;

    // Output control / readback fields
    localparam int PIN_LSB = 0;
    localparam int DI_LSB = 4;
    localparam int ASEL_LSB = 16;
    localparam int BSEL_LSB = 20;
    localparam int HOLD_LSB = 24;
    localparam int SRC_LSB = 28;

    // Reset values
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [1:0] SRATE_RESET = 2'h0;
    localparam logic [2:0] TBASE_RESET = 3'h0;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [31:0] PRESET_MID = 32'h8000_0000;
    localparam logic [31:0] PRESET_ZERO = 32'h0000_0000;

    // Timing at a 25 MHz pclk
    localparam int CLK_PERIOD_NS = 40;
    localparam int BASE_PERIOD_NS = 20000;
    localparam logic [8:0] BASE_LAST = 9'(BASE_PERIOD_NS / CLK_PERIOD_NS - 1);
    localparam logic [3:0] DECADE_LAST = 4'h9;
    localparam int TBASE_STAGES = 5;

    // Filter sampling rates in kHz against the pclk rate in kHz
    localparam logic [15:0] CLK_KHZ = 16'h61A8;
    localparam logic [15:0] RATE_8M_KHZ = 16'h1F40;
    localparam logic [15:0] RATE_4M_KHZ = 16'h0FA0;
    localparam logic [15:0] RATE_2M_KHZ = 16'h07D0;
    localparam logic [15:0] RATE_1M_KHZ = 16'h03E8;
    localparam int FILT_DEPTH = 4;

    typedef logic [3:0] eccr_nib_t;

    // Per-channel event pulses from the counter core
    typedef struct packed {
        eccr_nib_t up_wrap;
        eccr_nib_t down_wrap;
        eccr_nib_t marker;
        eccr_nib_t above_match;
        eccr_nib_t below_match;
    } eccr_evt_s;

    function automatic logic [15:0] eccr_rate_khz(input logic [1:0] sel);
        case (sel)
            2'h0: return RATE_8M_KHZ;
            2'h1: return RATE_4M_KHZ;
            2'h2: return RATE_2M_KHZ;
            default: return RATE_1M_KHZ;
        endcase
    endfunction

    function automatic logic eccr_mapped(input logic [11:0] a);
        return (a == ADDR_STATUS) || (a == ADDR_CLOCK) || (a == ADDR_CARD) ||
               (a == ADDR_LOAD) || (a == ADDR_DIO) || (a == ADDR_PRESET);
    endfunction

    function automatic logic [31:0] eccr_preset(input logic sel);
        return sel ? PRESET_ZERO : PRESET_MID;
    endfunction

endpackage

//--- eccr_filter.sv
`timescale 1ns/1ps
module eccr_filter import eccr_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_en,
    input wire logic [3:0] din,
    output logic [3:0] dout
);

    typedef struct packed {
        logic [FILT_DEPTH-2:0][3:0] hist;
        logic [3:0] out;
    } eccr_filt_s;

    eccr_filt_s q;
    eccr_filt_s d;
    logic [3:0] all_one;
    logic [3:0] all_zero;

    always_comb begin
        d = q;
        all_one = din;
        all_zero = ~din;
        for (int k = 0; k < FILT_DEPTH - 1; k++) begin
            all_one = all_one & q.hist[k];
            all_zero = all_zero & ~q.hist[k];
        end
        if (sample_en) begin
            // Four equal samples in a row move the output; anything shorter is dropped
            d.out = (q.out & ~all_zero) | all_one;
            d.hist[0] = din;
            for (int k = 1; k < FILT_DEPTH - 1; k++) begin
                d.hist[k] = q.hist[k-1];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.out;

    AST_FILT_ON_STROBE: assert property (@(posedge pclk) disable iff (!presetn)
        (q.out != $past(q.out)) |-> $past(sample_en) && (((q.out ^ $past(q.out)) & (q.out ^ $past(din))) == 4'h0))
        else $error("Filter output moved without a run of equal samples");

endmodule

//--- eccr_regs.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Read of 0x20 returns per-channel flags, timer flag and overall interrupt flag.
// - Read of 0x24 clears pending interrupt; returned data has no meaning.
// - Writes at 0x24 set clock control; reads only clear interrupts.
// - Filter rate field 1:0 selects 8, 4, 2 or 1 MHz sampling.
// - Timer base field 26:24 selects 50k, 5k, 500, 50, 5 Hz; others unused.
// - Writing 1 to bit n at 0x28 snapshots counter n.
// - Read of 0x28 returns card number in bits 3:0, rest zero.
// - Card number is plain unsigned binary, bit 0 least significant.
// - At 0x28 writes go to snapshot command, reads to card number.
// - Writing 1 to bit n at 0x2C loads counter n with its preset.
// - Write of 0x30 sets output values and per-channel output configuration.
// - Read of 0x30 returns inputs 7:4, outputs 3:0, configuration 31:16.
// - Above-match select lets counter above compare drive the output.
// - Below-match select lets counter below compare drive the output.
// - Hold style 0 gives one-clock pulse, 1 holds until interrupt clear.
// - Source select 0 drives written value, 1 lets compare events drive.
// - Filter output changes only after four equal consecutive samples.
// - Periodic timer repeats pulses from 20 us up to 51 s.
// - Counter preset is 80000000h for select 0, zero for select 1.
module eccr_regs import eccr_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire eccr_evt_s count_evt,
    input wire logic [3:0] din_raw,
    input wire logic [3:0] card_number,
    output logic [3:0] snapshot_cmd,
    output logic [3:0] count_clear_cmd,
    output logic [3:0][31:0] count_preset_value,
    output logic filter_sample,
    output logic [1:0] filter_sample_rate,
    output logic [3:0] din_filtered,
    output logic periodic_tick,
    output logic [3:0] output_pin_value,
    output logic irq
);

    typedef struct packed {
        logic [31:0] status;
        logic [31:0] enables;
        logic [1:0] srate;
        logic [2:0] tbase;
        logic [7:0] divisor;
        logic [3:0] out_val;
        logic [3:0] above_sel;
        logic [3:0] below_sel;
        logic [3:0] hold_style;
        logic [3:0] src_sel;
        logic [3:0] preset_sel;
        logic [3:0] held;
        logic [3:0] snap;
        logic [3:0] load;
        logic [3:0] dout;
        logic [3:0] din_prev;
        logic [15:0] acc;
        logic sample;
        logic [8:0] pre_cnt;
        logic [TBASE_STAGES-2:0][3:0] dec_cnt;
        logic [7:0] div_cnt;
        logic tick;
        logic irq;
        logic [31:0] rdata;
        logic slverr;
    } eccr_state_s;

    eccr_state_s q;
    eccr_state_s d;

    logic apb_setup;
    logic apb_acc;
    logic wr_done;
    logic rd_done;
    logic clr;
    logic [31:0] read_mux;
    logic [31:0] set_vec;
    logic [3:0] hit;
    logic [3:0] din_f;
    logic [TBASE_STAGES-1:0] stg;
    logic sel_tick;
    logic expire;
    logic [16:0] acc_sum;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign apb_setup = psel && !penable;
    assign apb_acc = psel && penable;
    assign wr_done = apb_acc && pwrite && eccr_mapped(paddr);
    assign rd_done = apb_acc && !pwrite && eccr_mapped(paddr);
    // Read side of 0x24 only; a write there never clears
    assign clr = rd_done && (paddr == ADDR_CLOCK);

    eccr_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .sample_en(q.sample),
        .din(din_raw),
        .dout(din_f)
    );

    // Read data is captured in setup so prdata comes from a flop with zero waits
    always_comb begin
        read_mux = '0;
        case (paddr)
            ADDR_STATUS: begin
                read_mux = q.status;
                read_mux[POS_ALL] = q.irq;
            end
            ADDR_CARD: read_mux[3:0] = card_number;
            ADDR_DIO: begin
                read_mux[PIN_LSB +: 4] = q.dout;
                read_mux[DI_LSB +: 4] = din_f;
                read_mux[ASEL_LSB +: 4] = q.above_sel;
                read_mux[BSEL_LSB +: 4] = q.below_sel;
                read_mux[HOLD_LSB +: 4] = q.hold_style;
                read_mux[SRC_LSB +: 4] = q.src_sel;
            end
            ADDR_PRESET: read_mux[3:0] = q.preset_sel;
            default: read_mux = '0;
        endcase
    end

    // Time base: 50 kHz prescale, then decade stages down to 5 Hz
    always_comb begin
        stg = '0;
        stg[0] = (q.pre_cnt == BASE_LAST);
        for (int k = 1; k < TBASE_STAGES; k++) begin
            stg[k] = stg[k-1] && (q.dec_cnt[k-1] == DECADE_LAST);
        end
        sel_tick = (q.tbase < 3'(TBASE_STAGES)) ? stg[q.tbase] : 1'b0;
        // Divisor zero parks the timer rather than running at an odd rate
        expire = sel_tick && (q.divisor != 8'h00) && (q.div_cnt == q.divisor - 8'h01);
    end

    always_comb begin
        hit = (q.above_sel & count_evt.above_match) | (q.below_sel & count_evt.below_match);
        set_vec = '0;
        set_vec[POS_UP +: 4] = count_evt.up_wrap;
        set_vec[POS_DOWN +: 4] = count_evt.down_wrap;
        set_vec[POS_MARK +: 4] = count_evt.marker;
        set_vec[POS_DIN +: 4] = din_f & ~q.din_prev;
        set_vec[POS_ABOVE +: 4] = count_evt.above_match;
        set_vec[POS_BELOW +: 4] = count_evt.below_match;
        set_vec[POS_TICK] = expire;
    end

    always_comb begin
        d = q;
        d.snap = '0;
        d.load = '0;
        d.tick = 1'b0;
        d.sample = 1'b0;
        acc_sum = {1'b0, q.acc} + {1'b0, eccr_rate_khz(q.srate)};

        if (apb_setup) begin
            d.rdata = read_mux;
            d.slverr = !eccr_mapped(paddr);
        end

        if (wr_done) begin
            case (paddr)
                ADDR_STATUS: d.enables = pwdata;
                ADDR_CLOCK: begin
                    d.srate = pwdata[SRATE_LSB +: 2];
                    d.divisor = pwdata[DIV_LSB +: 8];
                    d.tbase = pwdata[TBASE_LSB +: 3];
                end
                ADDR_CARD: d.snap = pwdata[3:0];
                ADDR_LOAD: d.load = pwdata[3:0];
                ADDR_DIO: begin
                    d.out_val = pwdata[PIN_LSB +: 4];
                    d.above_sel = pwdata[ASEL_LSB +: 4];
                    d.below_sel = pwdata[BSEL_LSB +: 4];
                    d.hold_style = pwdata[HOLD_LSB +: 4];
                    d.src_sel = pwdata[SRC_LSB +: 4];
                end
                ADDR_PRESET: d.preset_sel = pwdata[3:0];
                default: d.enables = q.enables;
            endcase
        end

        // Fractional rate: average strobe rate is exact though pclk is no multiple
        if (acc_sum >= {1'b0, CLK_KHZ}) begin
            d.acc = 16'(acc_sum - {1'b0, CLK_KHZ});
            d.sample = 1'b1;
        end else begin
            d.acc = acc_sum[15:0];
        end

        d.pre_cnt = stg[0] ? '0 : q.pre_cnt + 9'h001;
        for (int k = 0; k < TBASE_STAGES - 1; k++) begin
            if (stg[k]) begin
                d.dec_cnt[k] = (q.dec_cnt[k] == DECADE_LAST) ? 4'h0 : q.dec_cnt[k] + 4'h1;
            end
        end
        if (wr_done && paddr == ADDR_CLOCK) begin
            d.div_cnt = '0;
        end else if (expire) begin
            d.div_cnt = '0;
            d.tick = 1'b1;
        end else if (sel_tick) begin
            d.div_cnt = q.div_cnt + 8'h01;
        end

        // Set beats clear in the same cycle
        d.status = (clr ? '0 : q.status) | set_vec;
        d.held = (clr ? '0 : q.held) | hit;
        for (int n = 0; n < NCH; n++) begin
            if (q.src_sel[n]) begin
                d.dout[n] = q.hold_style[n] ? d.held[n] : hit[n];
            end else begin
                d.dout[n] = q.out_val[n];
            end
        end
        d.din_prev = din_f;
        d.irq = q.enables[POS_ALL] && |(q.status & q.enables);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.enables <= ENABLE_RESET;
            q.srate <= SRATE_RESET;
            q.tbase <= TBASE_RESET;
            q.divisor <= DIV_RESET;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = apb_acc && q.slverr;
    assign snapshot_cmd = q.snap;
    assign count_clear_cmd = q.load;
    assign filter_sample = q.sample;
    assign filter_sample_rate = q.srate;
    assign din_filtered = din_f;
    assign periodic_tick = q.tick;
    assign output_pin_value = q.dout;
    assign irq = q.irq;

    always_comb begin
        for (int n = 0; n < NCH; n++) begin
            count_preset_value[n] = eccr_preset(q.preset_sel[n]);
        end
    end

    sequence s_clear_read;
        clr && (set_vec == '0) && (q.held == '0 || hit == '0);
    endsequence

    sequence s_clock_write;
        wr_done && (paddr == ADDR_CLOCK);
    endsequence

    sequence s_held_event;
        q.src_sel[0] && q.hold_style[0] && hit[0];
    endsequence

    sequence s_pulse_event;
        q.src_sel[1] && !q.hold_style[1];
    endsequence

    AST_CLEAR_ON_READ: assert property (s_clear_read |=> (q.status == '0))
        else $error("Status flags survived a clear read");

    AST_WRITE_KEEPS_FLAGS: assert property (s_clock_write |=>
        (($past(q.status) & ~q.status) == '0) && (q.srate == $past(pwdata[SRATE_LSB +: 2])))
        else $error("Clock setup write disturbed flags or was not stored");

    AST_SLOW_SAMPLE: assert property ((q.sample && q.srate == 2'h3) |=> !q.sample [*8])
        else $error("1 MHz sampling strobe came too soon");

    AST_UNUSED_BASE: assert property ((q.tbase > 3'h4) |-> !sel_tick)
        else $error("Unused time base code produced ticks");

    AST_SNAPSHOT: assert property ((wr_done && paddr == ADDR_CARD) |=>
        (snapshot_cmd == $past(pwdata[3:0])) ##1 (snapshot_cmd == '0 || $past(wr_done)))
        else $error("Snapshot command not a one-cycle copy of write data");

    AST_CARD_READ: assert property ((apb_setup && !pwrite && paddr == ADDR_CARD) |=>
        (prdata == {28'h0, $past(card_number)}))
        else $error("Card number read returned wrong data");

    AST_CLEAR_CMD: assert property ((wr_done && paddr == ADDR_LOAD) |=>
        (count_clear_cmd == $past(pwdata[3:0])))
        else $error("Counter load command does not follow write data");

    AST_PLAIN_OUTPUT: assert property ((wr_done && paddr == ADDR_DIO && pwdata[SRC_LSB +: 4] == 4'h0)
        |=> ##1 (output_pin_value == $past(pwdata[PIN_LSB +: 4], 2)))
        else $error("Output pins do not follow written values");

    AST_INPUT_READBACK: assert property ((apb_setup && !pwrite && paddr == ADDR_DIO) |=>
        (prdata[DI_LSB +: 4] == $past(din_f)))
        else $error("Input levels missing from readback");

    AST_HELD_LEVEL: assert property (s_held_event ##1 !clr |=> output_pin_value[0])
        else $error("Held compare output not asserted");

    AST_TICK_FLAG: assert property (expire |=> periodic_tick && q.status[POS_TICK])
        else $error("Timer expiry did not set its flag");

    AST_IRQ_RAISE: assert property ((q.enables[POS_ALL] && |(q.status & q.enables))
        |=> irq)
        else $error("Enabled pending flag did not raise interrupt");

    AST_IRQ_MASKED: assert property (!q.enables[POS_ALL] |=> !irq)
        else $error("Interrupt raised with overall enable off");

    AST_READ_KEEPS_CLOCK: assert property ((rd_done && paddr == ADDR_CLOCK) |=>
        $stable(q.srate) && $stable(q.tbase) && $stable(q.divisor))
        else $error("Clear read altered clock setup");

    AST_FAST_SAMPLE: assert property ((q.sample && q.srate == 2'h0) |=> !q.sample)
        else $error("8 MHz sampling strobe on two cycles in a row");

    AST_SNAP_ONLY_ON_WRITE: assert property ((snapshot_cmd != '0) |->
        $past(wr_done && paddr == ADDR_CARD))
        else $error("Snapshot command without a write");

    AST_LOAD_ONLY_ON_WRITE: assert property ((count_clear_cmd != '0) |->
        $past(wr_done && paddr == ADDR_LOAD))
        else $error("Counter load command without a write");

    AST_PULSE_STYLE: assert property (s_pulse_event |=> (output_pin_value[1] == $past(hit[1])))
        else $error("Pulse style output does not follow compare events");

endmodule

//--- eccr_regs_test.sv
`timescale 1ns/1ps
module eccr_regs_test import eccr_pkg::*; ;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    eccr_evt_s count_evt;
    logic [3:0] din_raw;
    logic [3:0] card_number;
    logic [3:0] snapshot_cmd;
    logic [3:0] count_clear_cmd;
    logic [3:0][31:0] count_preset_value;
    logic filter_sample;
    logic [1:0] filter_sample_rate;
    logic [3:0] din_filtered;
    logic periodic_tick;
    logic [3:0] output_pin_value;
    logic irq;
    logic [31:0] rdat;
    logic rerr;
    int n_mismatch = 0;
    int checked = 0;

    eccr_regs dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_evt(count_evt), .din_raw(din_raw), .card_number(card_number),
        .snapshot_cmd(snapshot_cmd), .count_clear_cmd(count_clear_cmd),
        .count_preset_value(count_preset_value), .filter_sample(filter_sample),
        .filter_sample_rate(filter_sample_rate), .din_filtered(din_filtered),
        .periodic_tick(periodic_tick), .output_pin_value(output_pin_value), .irq(irq)
    );

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    task finish_test;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Idle cycle first, so psel is never lowered and raised in one step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task evt(input eccr_evt_s e);
        @(posedge pclk);
        count_evt <= e;
        @(posedge pclk);
        count_evt <= '0;
    endtask

    // Pulses are short, so every cycle of the window is looked at
    task watch(input int sel, input logic [3:0] m, output logic [3:0] acc, output int hits);
        logic [3:0] v;
        acc = 4'h0;
        hits = 0;
        repeat (8) begin
            #1;
            v = (sel == 0) ? snapshot_cmd : (sel == 1) ? count_clear_cmd : output_pin_value;
            v = v & m;
            acc = acc | v;
            if (v != 4'h0) hits++;
            @(posedge pclk);
        end
    endtask

    task tick(output int t);
        t = 0;
        do begin
            @(posedge pclk);
            #1;
            t++;
        end while (periodic_tick !== 1'b1 && t < 20000);
        if (periodic_tick !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end
    endtask

    initial begin
        int i;
        int n;
        int t;
        int hits;
        logic [3:0] acc;
        logic [31:0] tcfg [3];
        int tper [3];
        tcfg = '{32'h0001_0000, 32'h0002_0000, 32'h0101_0000};
        tper = '{500, 1000, 5000};
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
        count_evt = '0;
        din_raw = 4'h0;
        card_number = 4'h0;
        cyc(16);
        presetn <= 1'b1;
        #1;
        chk(irq, 32'h0);
        chk(count_preset_value[1], 32'h8000_0000);
        for (i = 0; i < 4; i++) begin
            card_number <= 4'(i * 5);
            rd(ADDR_CARD);
            chk(rdat, 32'(i * 5));
        end
        wr(ADDR_CARD, 32'h0000_000A);
        watch(0, 4'hF, acc, hits);
        chk(acc, 32'hA);
        chk(hits, 1);
        wr(ADDR_CARD, 32'h0000_0000);
        watch(0, 4'hF, acc, hits);
        chk(acc, 32'h0);
        wr(ADDR_LOAD, 32'h0000_0005);
        watch(1, 4'hF, acc, hits);
        chk(acc, 32'h5);
        chk(hits, 1);
        rd(ADDR_LOAD);
        chk({rdat[31:1], rerr}, 32'h0);
        wr(12'h040, 32'hFFFF_FFFF);
        chk(rerr, 32'h1);
        rd(12'h040);
        chk({rdat[30:0], rerr}, 32'h1);
        wr(ADDR_PRESET, 32'h0000_0003);
        #1;
        chk(count_preset_value[0], 32'h0000_0000);
        chk(count_preset_value[2], 32'h8000_0000);
        // Flags with every enable off: sticky but no request
        evt(20'h12481);
        cyc(3);
        #1;
        chk(irq, 32'h0);
        rd(ADDR_STATUS);
        chk(rdat, 32'h0018_0421);
        wr(ADDR_STATUS, 32'h8000_0001);
        cyc(3);
        #1;
        chk(irq, 32'h1);
        wr(ADDR_CLOCK, 32'h0000_0000);
        rd(ADDR_STATUS);
        chk(rdat, 32'h8018_0421);
        rd(ADDR_CLOCK);
        chk(rdat, 32'h0);
        cyc(2);
        #1;
        chk(irq, 32'h0);
        rd(ADDR_STATUS);
        chk(rdat, 32'h0);
        for (i = 0; i < 4; i++) begin
            wr(ADDR_CLOCK, 32'(i));
            #1;
            chk(filter_sample_rate, 32'(i));
            n = 0;
            repeat (1000) begin
                @(posedge pclk);
                #1;
                if (filter_sample === 1'b1) n++;
            end
            chk(n >= (40 << (3 - i)) - 1 && n <= (40 << (3 - i)) + 1, 32'h1);
        end
        // Slowest rate: a 40-cycle glitch spans under two samples
        @(posedge pclk);
        din_raw <= 4'h1;
        cyc(40);
        din_raw <= 4'h0;
        cyc(150);
        #1;
        chk(din_filtered, 32'h0);
        @(posedge pclk);
        din_raw <= 4'h6;
        cyc(150);
        #1;
        chk(din_filtered, 32'h6);
        rd(ADDR_DIO);
        chk(rdat, 32'h0000_0060);
        rd(ADDR_STATUS);
        chk(rdat, 32'h0000_6000);
        rd(ADDR_CLOCK);
        wr(ADDR_DIO, 32'h7121_0008);
        cyc(3);
        #1;
        chk(output_pin_value, 32'h8);
        rd(ADDR_DIO);
        chk(rdat, 32'h7121_0068);
        evt(20'h00052);
        watch(2, 4'h6, acc, hits);
        chk(acc, 32'h2);
        chk(hits, 1);
        chk(output_pin_value, 32'h9);
        rd(ADDR_CLOCK);
        cyc(3);
        #1;
        chk(output_pin_value, 32'h8);
        for (i = 0; i < 3; i++) begin
            wr(ADDR_CLOCK, tcfg[i]);
            tick(t);
            tick(t);
            chk(t, tper[i]);
        end
        rd(ADDR_STATUS);
        chk(rdat & 32'h1000_0000, 32'h1000_0000);
        // Unused base code must park the timer
        wr(ADDR_CLOCK, 32'h0501_0000);
        n = 0;
        repeat (600) begin
            @(posedge pclk);
            #1;
            if (periodic_tick === 1'b1) n++;
        end
        chk(n, 32'h0);
        finish_test();
    end

    initial begin
        #4000000;
        n_mismatch++;
        finish_test();
    end
endmodule
